// File: design/tpwm_timer.sv
// PWM waveform generator of a 16-bit timer with an AHB-Lite register port.
//
// Implementation choices: the register addresses and the AHB-Lite interface to the registers.
`timescale 1ns/100ps
module tpwm_timer #(
    parameter int COUNT_WIDTH = 16
) (
    input  wire logic        core_clk,
    input  wire logic        sys_rst,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic             hreadyout,
    output logic [1:0]       hresp,
    output logic [31:0]      hrdata,
    input  wire logic        timerTick,
    output logic             chanAWaveOut,
    output logic             chanAPinOe,
    output logic             chanBWaveOut,
    output logic             chanBPinOe
);

    // ------------------------------------------------------------
    // Parameter check.
    // ------------------------------------------------------------
    if (COUNT_WIDTH != tpwm_pkg::CNT_W) begin : g_bad_width
        $error("COUNT_WIDTH must equal the 16-bit counter width");
    end

    typedef logic [COUNT_WIDTH-1:0] tpwm_cnt_t;

    // ------------------------------------------------------------
    // Functions.
    // ------------------------------------------------------------
    // Drops compare bits above the fixed resolution of the mode.
    function automatic tpwm_cnt_t maskCompare(input tpwm_cnt_t value, input logic [3:0] mode);
        tpwm_cnt_t m;
        m = tpwm_pkg::CNT_MAX;
        if (mode == tpwm_pkg::WM_PC8 || mode == tpwm_pkg::WM_FAST8) begin
            m = tpwm_pkg::TOP_8BIT;
        end else if (mode == tpwm_pkg::WM_PC9 || mode == tpwm_pkg::WM_FAST9) begin
            m = tpwm_pkg::TOP_9BIT;
        end else if (mode == tpwm_pkg::WM_PC10 || mode == tpwm_pkg::WM_FAST10) begin
            m = tpwm_pkg::TOP_10BIT;
        end
        return value & m;
    endfunction

    // Next level of one channel output for the current timer tick.
    function automatic logic nextWave(input logic cur, input logic [1:0] om, input logic match,
                                      input logic fast, input logic dual, input logic wrapTop,
                                      input logic downMatch, input logic toggleOk);
        logic w;
        w = cur;
        if (om == tpwm_pkg::OM_TOGGLE) begin
            if (toggleOk && match) begin
                w = ~cur;
            end
        end else if (om != tpwm_pkg::OM_OFF && fast) begin
            if (wrapTop) begin
                w = (om == tpwm_pkg::OM_CLEAR);
            end else if (match) begin
                w = (om == tpwm_pkg::OM_SET);
            end
        end else if (om != tpwm_pkg::OM_OFF && dual && match) begin
            w = downMatch ? (om == tpwm_pkg::OM_CLEAR) : (om == tpwm_pkg::OM_SET);
        end
        return w;
    endfunction

    // ------------------------------------------------------------
    // Registers.
    // ------------------------------------------------------------
    logic [3:0]              waveMode;
    logic [1:0]              chanAOutputMode;
    logic [1:0]              chanBOutputMode;
    logic                    pinDirA;
    logic                    pinDirB;
    tpwm_cnt_t               bufA;
    tpwm_cnt_t               bufB;
    tpwm_cnt_t               compareRegA;
    tpwm_cnt_t               compareRegB;
    tpwm_cnt_t               captureReg;
    tpwm_cnt_t               countValue;
    logic                    countDown;
    logic [tpwm_pkg::FLG_W-1:0] flags;
    logic                    wrPend;
    logic [7:0]              wrAddr;

    // ------------------------------------------------------------
    // Bus decode.
    // ------------------------------------------------------------
    wire        addrPhase = hsel & hready & htrans[1];
    wire        mappedLow = (haddr[31:8] == 24'h000000);
    wire [7:0]  rdAddr    = haddr[7:0];
    wire        wrCtrl    = wrPend & (wrAddr == tpwm_pkg::OFS_CTRL);
    wire        wrCmpA    = wrPend & (wrAddr == tpwm_pkg::OFS_CMPA);
    wire        wrCmpB    = wrPend & (wrAddr == tpwm_pkg::OFS_CMPB);
    wire        wrCapt    = wrPend & (wrAddr == tpwm_pkg::OFS_CAPT);
    wire        wrFlags   = wrPend & (wrAddr == tpwm_pkg::OFS_FLAGS);
    wire [31:0] ctrlWord  = {22'h000000, pinDirB, pinDirA, chanBOutputMode, chanAOutputMode, waveMode};
    wire [31:0] next_rdata =
        !mappedLow                          ? 32'h00000000 :
        (rdAddr == tpwm_pkg::OFS_CTRL)      ? ctrlWord :
        (rdAddr == tpwm_pkg::OFS_CMPA)      ? {16'h0000, bufA} :
        (rdAddr == tpwm_pkg::OFS_CMPB)      ? {16'h0000, bufB} :
        (rdAddr == tpwm_pkg::OFS_CAPT)      ? {16'h0000, captureReg} :
        (rdAddr == tpwm_pkg::OFS_COUNT)     ? {16'h0000, countValue} :
        (rdAddr == tpwm_pkg::OFS_FLAGS)     ? {28'h0000000, flags} : 32'h00000000;

    assign hreadyout = 1'b1;
    assign hresp     = tpwm_pkg::HRESP_OKAY;

    // ------------------------------------------------------------
    // Mode decode and TOP selection.
    // ------------------------------------------------------------
    wire isFast = (waveMode == tpwm_pkg::WM_FAST8) | (waveMode == tpwm_pkg::WM_FAST9) |
                  (waveMode == tpwm_pkg::WM_FAST10) | (waveMode == tpwm_pkg::WM_FAST_CAPT) |
                  (waveMode == tpwm_pkg::WM_FAST_CMPA);
    wire isPc   = (waveMode == tpwm_pkg::WM_PC8) | (waveMode == tpwm_pkg::WM_PC9) |
                  (waveMode == tpwm_pkg::WM_PC10) | (waveMode == tpwm_pkg::WM_PC_CAPT) |
                  (waveMode == tpwm_pkg::WM_PC_CMPA);
    wire isPfc  = (waveMode == tpwm_pkg::WM_PFC_CAPT) | (waveMode == tpwm_pkg::WM_PFC_CMPA);
    wire isDual = isPc | isPfc;
    wire topIsCapt = (waveMode == tpwm_pkg::WM_FAST_CAPT) | (waveMode == tpwm_pkg::WM_PC_CAPT) |
                     (waveMode == tpwm_pkg::WM_PFC_CAPT);
    wire topIsCmpA = (waveMode == tpwm_pkg::WM_FAST_CMPA) | (waveMode == tpwm_pkg::WM_PC_CMPA) |
                     (waveMode == tpwm_pkg::WM_PFC_CMPA);
    // The capture register feeds TOP directly, with no buffer.
    wire tpwm_cnt_t top =
        topIsCapt ? captureReg :
        topIsCmpA ? compareRegA :
        (waveMode == tpwm_pkg::WM_PC8 || waveMode == tpwm_pkg::WM_FAST8) ? tpwm_pkg::TOP_8BIT :
        (waveMode == tpwm_pkg::WM_PC9 || waveMode == tpwm_pkg::WM_FAST9) ? tpwm_pkg::TOP_9BIT :
        (waveMode == tpwm_pkg::WM_PC10 || waveMode == tpwm_pkg::WM_FAST10) ? tpwm_pkg::TOP_10BIT :
        tpwm_pkg::CNT_MAX;

    wire atTop    = (countValue == top);
    wire atBottom = (countValue == tpwm_pkg::CNT_BOTTOM);
    wire matchA   = (countValue == compareRegA);
    wire matchB   = (countValue == compareRegB);
    // Phase correct reloads at TOP so each period starts there; frequency correct at BOTTOM.
    wire updatePoint = isFast ? atTop : isPc ? atTop : isPfc ? atBottom : 1'b1;
    // Outside the PWM modes the active compares follow their buffers on every clock.
    wire loadActive  = updatePoint & (timerTick | ~(isFast | isDual));
    // A match at TOP counts as downcounting and one at BOTTOM as upcounting.
    wire downMatch   = atTop | (countValue != tpwm_pkg::CNT_BOTTOM && countDown);
    wire toggleOkA   = topIsCmpA;

    // ------------------------------------------------------------
    // Counter next state.
    // ------------------------------------------------------------
    wire tpwm_cnt_t countInc = countValue + 1'b1;
    wire tpwm_cnt_t countDec = countValue - 1'b1;
    // A TOP below the count is missed: the counter runs on and wraps at the 16-bit limit.
    wire tpwm_cnt_t next_count =
        !timerTick  ? countValue :
        isFast      ? (atTop ? tpwm_pkg::CNT_BOTTOM : countInc) :
        !isDual     ? countInc :
        countDown   ? (atBottom ? countInc : countDec) :
                      (atTop ? countDec : countInc);
    wire next_down =
        (!timerTick || !isDual) ? (countDown & isDual) :
        countDown ? ~atBottom : atTop;

    // ------------------------------------------------------------
    // Flag events; a set in the clearing cycle wins.
    // ------------------------------------------------------------
    // Outside the PWM modes the overflow comes as the count leaves its 16-bit maximum.
    wire ovfEvent  = timerTick & (isFast ? atTop : isDual ? atBottom :
                                  (countValue == tpwm_pkg::CNT_MAX));
    wire captEvent = timerTick & topIsCapt & atTop;
    wire [tpwm_pkg::FLG_W-1:0] setMask = {captEvent, timerTick & matchB,
                                          timerTick & matchA, ovfEvent};
    wire [tpwm_pkg::FLG_W-1:0] clrMask = wrFlags ? hwdata[tpwm_pkg::FLG_W-1:0] : '0;
    wire [tpwm_pkg::FLG_W-1:0] next_flags = (flags & ~clrMask) | setMask;

    // ------------------------------------------------------------
    // Output waveform next state.
    // ------------------------------------------------------------
    wire next_waveA = timerTick ? nextWave(chanAWaveOut, chanAOutputMode, matchA, isFast, isDual,
                                           atTop, downMatch, toggleOkA) : chanAWaveOut;
    wire next_waveB = timerTick ? nextWave(chanBWaveOut, chanBOutputMode, matchB, isFast, isDual,
                                           atTop, downMatch, 1'b0) : chanBWaveOut;
    // Toggle reaches channel A only when compare A sets TOP; channel B never toggles in PWM.
    wire connA = (chanAOutputMode != tpwm_pkg::OM_OFF) &
                 ((chanAOutputMode != tpwm_pkg::OM_TOGGLE) | toggleOkA | ~(isFast | isDual));
    wire connB = (chanBOutputMode != tpwm_pkg::OM_OFF) &
                 ((chanBOutputMode != tpwm_pkg::OM_TOGGLE) | ~(isFast | isDual));

    assign chanAPinOe = connA & pinDirA;
    assign chanBPinOe = connB & pinDirB;

    // ------------------------------------------------------------
    // Bus registers.
    // ------------------------------------------------------------
    // Writes land at the end of the data phase, when hwdata is valid.
    // Read data is captured at the address phase and held until the next read.
    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            wrPend <= 1'b0;
            wrAddr <= 8'h00;
            hrdata <= 32'h00000000;
        end else begin
            wrPend <= addrPhase & hwrite & mappedLow;
            wrAddr <= rdAddr;
            if (addrPhase && !hwrite) begin
                hrdata <= next_rdata;
            end
        end
    end

    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            waveMode        <= 4'h0;
            chanAOutputMode <= 2'h0;
            chanBOutputMode <= 2'h0;
            pinDirA         <= 1'b0;
            pinDirB         <= 1'b0;
        end else if (wrCtrl) begin
            waveMode        <= hwdata[tpwm_pkg::CTRL_MODE +: 4];
            chanAOutputMode <= hwdata[tpwm_pkg::CTRL_OMA +: 2];
            chanBOutputMode <= hwdata[tpwm_pkg::CTRL_OMB +: 2];
            pinDirA         <= hwdata[tpwm_pkg::CTRL_DIRA];
            pinDirB         <= hwdata[tpwm_pkg::CTRL_DIRB];
        end
    end

    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            bufA       <= '0;
            bufB       <= '0;
            captureReg <= '0;
        end else begin
            if (wrCmpA) begin
                bufA <= maskCompare(hwdata[COUNT_WIDTH-1:0], waveMode);
            end
            if (wrCmpB) begin
                bufB <= maskCompare(hwdata[COUNT_WIDTH-1:0], waveMode);
            end
            if (wrCapt) begin
                captureReg <= hwdata[COUNT_WIDTH-1:0];
            end
        end
    end

    // ------------------------------------------------------------
    // Timer core.
    // ------------------------------------------------------------
    // Every timer action is evaluated on the count seen before the edge,
    // so flags and outputs follow the tick edge directly.
    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            compareRegA  <= '0;
            compareRegB  <= '0;
            countValue   <= '0;
            countDown    <= 1'b0;
            flags        <= '0;
            chanAWaveOut <= 1'b0;
            chanBWaveOut <= 1'b0;
        end else begin
            if (loadActive) begin
                compareRegA <= bufA;
                compareRegB <= bufB;
            end
            countValue   <= next_count;
            countDown    <= next_down;
            flags        <= next_flags;
            chanAWaveOut <= next_waveA;
            chanBWaveOut <= next_waveB;
        end
    end

    // ------------------------------------------------------------
    // Assertions.
    // ------------------------------------------------------------
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (sys_rst);

    a_fast_count_up: assert property (isFast && timerTick && !atTop && !wrCtrl |=>
        countValue == $past(countValue) + 1'b1) else $error("fast mode did not count up");

    a_fast_wrap_zero: assert property (isFast && timerTick && atTop && !wrCtrl |=>
        countValue == tpwm_pkg::CNT_BOTTOM) else $error("fast mode did not clear after TOP");

    a_fast_top_flags: assert property (isFast && timerTick && atTop |=>
        flags[tpwm_pkg::FLG_OVF] && (!$past(topIsCapt) || flags[tpwm_pkg::FLG_CAPT]))
        else $error("flags missing at fast TOP");

    a_cmp_match_flag: assert property (timerTick && matchB |=>
        flags[tpwm_pkg::FLG_CMPB]) else $error("compare B flag missing");

    a_mask_fixed_top: assert property (wrCmpA && (waveMode == tpwm_pkg::WM_FAST8) |=>
        bufA[COUNT_WIDTH-1:8] == '0) else $error("compare bits above 8 not masked");

    a_capt_immediate: assert property (wrCapt |=>
        captureReg == $past(hwdata[COUNT_WIDTH-1:0])) else $error("capture write not immediate");

    a_fast_load_top: assert property (isFast && timerTick && atTop |=>
        compareRegA == $past(bufA) && compareRegB == $past(bufB)) else $error("fast buffer not loaded");

    a_fast_clear_match: assert property (isFast && timerTick && matchA && !atTop &&
        chanAOutputMode == tpwm_pkg::OM_CLEAR |=> !chanAWaveOut) else $error("fast clear on match");

    a_pin_gated_dir: assert property (!pinDirA |-> !chanAPinOe)
        else $error("pin driven without direction bit");

    a_dual_top_once: assert property (isDual && timerTick && atTop && !countDown && !wrCtrl |=>
        countDown && countValue == $past(countValue) - 1'b1) else $error("TOP not held one tick");

    a_dual_bottom_ovf: assert property (isDual && timerTick && atBottom |=>
        flags[tpwm_pkg::FLG_OVF]) else $error("overflow flag missing at BOTTOM");

    a_pfc_load_bottom: assert property (isPfc && timerTick && !atBottom && !wrCmpA ##1 !wrCmpA |->
        compareRegA == $past(compareRegA)) else $error("frequency correct loaded off BOTTOM");

    a_dual_up_clear: assert property (isDual && timerTick && matchA && !downMatch &&
        chanAOutputMode == tpwm_pkg::OM_CLEAR |=> !chanAWaveOut) else $error("up match did not clear");

    // ------------------------------------------------------------
    // Counter direction, wrap, buffer timing and flags.
    // ------------------------------------------------------------
    a_dual_count_up: assert property (isDual && timerTick && !countDown && !atTop && !wrCtrl |=>
        countValue == $past(countValue) + 1'b1) else $error("dual mode did not count up");

    a_dual_count_down: assert property (isDual && timerTick && countDown && !atBottom && !wrCtrl |=>
        countValue == $past(countValue) - 1'b1) else $error("dual mode did not count down");

    a_dual_turn_bottom: assert property (isDual && timerTick && atBottom && countDown && !wrCtrl |=>
        !countDown && countValue == $past(countValue) + 1'b1) else $error("BOTTOM did not turn upward");

    a_pc_load_top: assert property (isPc && !(timerTick && atTop) |=>
        compareRegA == $past(compareRegA) && compareRegB == $past(compareRegB))
        else $error("phase correct loaded off TOP");

    a_fast_wrap_max: assert property (isFast && timerTick && !atTop && countValue == tpwm_pkg::CNT_MAX |=>
        atBottom) else $error("missed TOP did not wrap to zero");

    a_cmpa_match_flag: assert property (timerTick && matchA |=>
        flags[tpwm_pkg::FLG_CMPA]) else $error("compare A flag missing");

    a_capt_top_flag: assert property (timerTick && topIsCapt && atTop |=>
        flags[tpwm_pkg::FLG_CAPT]) else $error("capture flag missing at TOP");

    // ------------------------------------------------------------
    // Output levels and pin connection.
    // ------------------------------------------------------------
    a_fast_set_top: assert property (isFast && timerTick && atTop &&
        chanBOutputMode == tpwm_pkg::OM_CLEAR |=> chanBWaveOut) else $error("fast did not set at TOP");

    a_toggle_a_match: assert property (toggleOkA && timerTick && matchA &&
        chanAOutputMode == tpwm_pkg::OM_TOGGLE |=> chanAWaveOut != $past(chanAWaveOut))
        else $error("channel A did not toggle on match");

    a_dual_top_inv: assert property (isDual && timerTick && atTop && matchB &&
        chanBOutputMode == tpwm_pkg::OM_SET |=> !chanBWaveOut) else $error("inverted TOP compare not low");

    a_pin_gated_dir_b: assert property (!pinDirB |-> !chanBPinOe)
        else $error("pin B driven without direction bit");

    a_toggle_b_off: assert property ((isFast || isDual) && chanBOutputMode == tpwm_pkg::OM_TOGGLE |->
        !chanBPinOe) else $error("channel B toggle reached its pin");

    c_fast_wrap:   cover property (isFast && timerTick && atTop ##1 atBottom);
    c_dual_turn:   cover property (isDual && timerTick && atTop ##[1:8] countDown);
    c_toggle_a:    cover property (toggleOkA && chanAOutputMode == tpwm_pkg::OM_TOGGLE && timerTick && matchA);
    c_capt_flag:   cover property (captEvent);
    c_flag_clear:  cover property (wrFlags && |hwdata[tpwm_pkg::FLG_W-1:0]);

endmodule

// File: design/tpwm_pkg.sv
// Constants and types shared by the 16-bit PWM timer.
// Operation
// - Fast PWM counts up until TOP.
// - Fast PWM clears counter after TOP.
// - Fast PWM overflow flag at TOP, TOP-register flag too.
// - Compare flag set on every counter match.
// - Fixed TOP masks compare bits on write.
// - Capture register TOP is unbuffered, may wrap.
// - Compare A buffered, loaded at TOP in fast.
// - Fast PWM: clear on match, set at TOP.
// - Waveform reaches pin only with direction bit.
// - Fast compare zero spikes; TOP gives constant.
// - Mode 15 channel A toggle on match.
// - Phase correct counts up and down.
// - Dual-slope holds TOP one timer clock.
// - Phase correct: overflow at BOTTOM, load at TOP.
// - Phase correct periods start and end at TOP.
// - Phase correct: clear up-match, set down-match.
// - Phase correct extremes give constant levels.
// - Mode 11 channel A toggles, 50% duty.
// - Modes 8 and 9 dual-slope, same polarity.
// - Compare above TOP never matches.
// - Frequency correct loads and overflows at BOTTOM.
package tpwm_pkg;

    localparam int          CNT_W       = 16;

    // ------------------------------------------------------------
    // Register offsets (byte addresses).
    // ------------------------------------------------------------
    localparam logic [7:0]  OFS_CTRL    = 8'h00;
    localparam logic [7:0]  OFS_CMPA    = 8'h04;
    localparam logic [7:0]  OFS_CMPB    = 8'h08;
    localparam logic [7:0]  OFS_CAPT    = 8'h0c;
    localparam logic [7:0]  OFS_COUNT   = 8'h10;
    localparam logic [7:0]  OFS_FLAGS   = 8'h14;

    // ------------------------------------------------------------
    // Field positions.
    // ------------------------------------------------------------
    localparam int          CTRL_MODE   = 0;
    localparam int          CTRL_OMA    = 4;
    localparam int          CTRL_OMB    = 6;
    localparam int          CTRL_DIRA   = 8;
    localparam int          CTRL_DIRB   = 9;
    localparam int          CTRL_W      = 10;
    localparam int          FLG_OVF     = 0;
    localparam int          FLG_CMPA    = 1;
    localparam int          FLG_CMPB    = 2;
    localparam int          FLG_CAPT    = 3;
    localparam int          FLG_W       = 4;

    // ------------------------------------------------------------
    // Counter values and bus codes.
    // ------------------------------------------------------------
    localparam logic [15:0] TOP_8BIT    = 16'h00ff;
    localparam logic [15:0] TOP_9BIT    = 16'h01ff;
    localparam logic [15:0] TOP_10BIT   = 16'h03ff;
    localparam logic [15:0] CNT_MAX     = 16'hffff;
    localparam logic [15:0] CNT_BOTTOM  = 16'h0000;
    localparam logic [1:0]  HRESP_OKAY  = 2'h0;

    typedef enum logic [3:0] {
        WM_PC8   = 4'h1, WM_PC9   = 4'h2, WM_PC10  = 4'h3,
        WM_FAST8 = 4'h5, WM_FAST9 = 4'h6, WM_FAST10 = 4'h7,
        WM_PFC_CAPT = 4'h8, WM_PFC_CMPA = 4'h9,
        WM_PC_CAPT  = 4'ha, WM_PC_CMPA  = 4'hb,
        WM_FAST_CAPT = 4'he, WM_FAST_CMPA = 4'hf
    } tpwm_wave_mode_t;

    typedef enum logic [1:0] {
        OM_OFF = 2'h0, OM_TOGGLE = 2'h1, OM_CLEAR = 2'h2, OM_SET = 2'h3
    } tpwm_out_mode_t;

endpackage

// File: testbench/tpwm_pin_load.sv
// Port pin with a pull-down, driven by one PWM channel when its output enable is high.
`timescale 1ns/100ps
module tpwm_pin_load (
    input  wire logic waveOut,
    input  wire logic pinOe,
    output logic      pinLevel
);
    // An undriven pin falls to the pull-down level, never the last driven value.
    assign pinLevel = pinOe ? waveOut : 1'b0;
endmodule

// File: testbench/timer16_pwm_waveform_modes_bench.sv
// Self-checking bench for the PWM timer: registers, fast, phase correct and frequency correct modes.
`timescale 1ns/100ps
module timer16_pwm_waveform_modes_bench;
    logic        core_clk = 1'b0;
    logic        sys_rst  = 1'b1;
    logic        hsel     = 1'b0;
    logic [31:0] haddr    = 32'h0;
    logic [1:0]  htrans   = 2'h0;
    logic        hwrite   = 1'b0;
    logic [2:0]  hsize    = 3'h2;
    logic [31:0] hwdata   = 32'h0;
    logic        timerTick = 1'b0;
    logic        hreadyout, chanAWaveOut, chanAPinOe, chanBWaveOut, chanBPinOe, pinA, pinB;
    logic [1:0]  hresp;
    logic [31:0] hrdata;
    int          errorCnt = 0;
    int          checked  = 0;

    always #2.5 core_clk = ~core_clk;

    tpwm_timer u_tpwm_timer (.core_clk(core_clk), .sys_rst(sys_rst), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
        .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .timerTick(timerTick),
        .chanAWaveOut(chanAWaveOut), .chanAPinOe(chanAPinOe), .chanBWaveOut(chanBWaveOut),
        .chanBPinOe(chanBPinOe));
    tpwm_pin_load u_pin_a (.waveOut(chanAWaveOut), .pinOe(chanAPinOe), .pinLevel(pinA));
    tpwm_pin_load u_pin_b (.waveOut(chanBWaveOut), .pinOe(chanBPinOe), .pinLevel(pinB));

    task automatic endSim();
        $display("Comparisons %0d, mismatches %0d", checked, errorCnt);
        if (errorCnt == 0 && checked > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            errorCnt++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
        @(posedge core_clk);
        hsel <= 1'b1;
        haddr <= {24'h0, a};
        hwrite <= w;
        htrans <= 2'h2;
        @(posedge core_clk);
        while (hreadyout !== 1'b1) @(posedge core_clk);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        @(posedge core_clk);
        while (hreadyout !== 1'b1) @(posedge core_clk);
        r = hrdata;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] r;
        bus(1'b1, a, d, r);
    endtask

    task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] r;
        bus(1'b0, a, 32'h0, r);
        chk(r, exp);
        chk({29'h0, hreadyout, hresp}, {29'h0, 1'b1, tpwm_pkg::HRESP_OKAY});
    endtask

    task automatic doReset();
        @(posedge core_clk);
        sys_rst <= 1'b1;
        timerTick <= 1'b0;
        repeat (2) @(posedge core_clk);
        sys_rst <= 1'b0;
    endtask

    // Configures with the counter frozen near zero, so a small TOP is never overrun.
    task automatic run(input logic [31:0] ctl, ca, cb, cp, input int per, ha, hb);
        logic [31:0] na;
        logic [31:0] nb;
        na = 0;
        nb = 0;
        doReset();
        wr(tpwm_pkg::OFS_CMPA, ca);
        wr(tpwm_pkg::OFS_CMPB, cb);
        wr(tpwm_pkg::OFS_CAPT, cp);
        @(posedge core_clk) timerTick <= 1'b1;
        @(posedge core_clk) timerTick <= 1'b0;
        wr(tpwm_pkg::OFS_CTRL, ctl);
        @(posedge core_clk) timerTick <= 1'b1;
        repeat (2 * per) @(posedge core_clk);
        repeat (4 * per) begin
            @(posedge core_clk);
            na += pinA;
            nb += pinB;
        end
        chk(na, 4 * ha);
        chk(nb, 4 * hb);
    endtask

    task automatic flagChk();
        @(posedge core_clk) timerTick <= 1'b0;
        rdc(tpwm_pkg::OFS_FLAGS, 32'h0000000f);
        wr(tpwm_pkg::OFS_FLAGS, 32'h0000000f);
        rdc(tpwm_pkg::OFS_FLAGS, 32'h00000000);
    endtask

    task automatic t_regs();
        logic [3:0]  modes [3] = '{4'h1, 4'h6, 4'h7};
        logic [15:0] tops [3]  = '{16'h00ff, 16'h01ff, 16'h03ff};
        doReset();
        for (int i = 0; i < 7; i++) rdc(8'(4 * i), 32'h0);
        wr(tpwm_pkg::OFS_COUNT, 32'h00000055);
        rdc(tpwm_pkg::OFS_COUNT, 32'h0);
        wr(8'h18, 32'h00000005);
        rdc(8'h18, 32'h0);
        for (int i = 0; i < 3; i++) begin
            wr(tpwm_pkg::OFS_CTRL, {28'h0, modes[i]});
            wr(tpwm_pkg::OFS_CMPA, 32'h0000ffff);
            wr(tpwm_pkg::OFS_CMPB, 32'h0000ffff);
            rdc(tpwm_pkg::OFS_CMPA, {16'h0, tops[i]});
            rdc(tpwm_pkg::OFS_CMPB, {16'h0, tops[i]});
        end
        wr(tpwm_pkg::OFS_CTRL, 32'h0000000f);
        wr(tpwm_pkg::OFS_CMPA, 32'h0000ffff);
        rdc(tpwm_pkg::OFS_CMPA, 32'h0000ffff);
        $display("t_regs done");
    endtask

    task automatic t_fast();
        run(32'h39f, 5, 2, 0, 12, 6, 6);
        run(32'h3cf, 5, 0, 0, 6, 0, 5);
        run(32'h3ae, 7, 3, 7, 8, 8, 4);
        flagChk();
        run(32'h1e5, 16, 128, 0, 256, 17, 0);
        $display("t_fast done");
    endtask

    task automatic t_phase();
        run(32'h39b, 6, 2, 0, 24, 12, 8);
        run(32'h3aa, 0, 6, 6, 12, 0, 12);
        flagChk();
        run(32'h3f1, 100, 255, 0, 510, 310, 0);
        $display("t_phase done");
    endtask

    task automatic t_freq();
        run(32'h3e8, 2, 4, 6, 12, 4, 4);
        run(32'h399, 6, 7, 0, 24, 12, 0);
        $display("t_freq done");
    endtask

    initial begin
        #(5 * 20000);
        errorCnt++;
        endSim();
    end

    initial begin
        t_regs();
        t_fast();
        t_phase();
        t_freq();
        endSim();
    end
endmodule
